// file: src/dlink_pkg.sv
// constants, register map and carrier types for the data-link
// message buffer controller; assumes a byte-wide deframed link
`default_nettype none

package dlink_pkg;

    // axi byte address is four times the register index
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_CTRL = 12'h153;
    localparam logic [11:0] IDX_TXCNT = 12'h154;
    localparam logic [11:0] IDX_RXCNT = 12'h155;
    localparam logic [11:0] IDX_TXBUF0 = 12'h600;
    localparam logic [11:0] IDX_TXBUF1 = 12'h700;
    localparam logic [11:0] IDX_RXBUF0 = 12'h800;
    localparam logic [11:0] IDX_RXBUF1 = 12'h900;

    // message buffer depth in bytes, per buffer
    localparam logic [6:0] BUF_BYTES = 7'h60;
    // bit-oriented code word length taken from buffer start
    localparam logic [6:0] BOS_MSG_BYTES = 7'h02;

    // control register fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_FCS_BIT = 1;
    localparam int CTRL_IDLE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // count registers: select/pointer bit above a seven-bit count
    localparam int SEL_BIT = 7;
    localparam logic [6:0] COUNT_RESET = 7'h00;

    localparam logic [7:0] FLAG_OCTET = 8'h7E;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } link_byte_type;

    typedef enum {
        REG_CTRL, REG_TXCNT, REG_RXCNT,
        REG_TXB0, REG_TXB1, REG_RXB0, REG_RXB1, REG_NONE
    } region_type;

    typedef enum {
        TX_IDLE, TX_OPEN, TX_BODY, TX_FCS_LO, TX_FCS_HI, TX_CLOSE
    } tx_state_type;

endpackage

`default_nettype wire

// file: src/link_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`default_nettype none

module link_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_type;

    fifo_state_type s_q, s_d;
    logic push, pop;

    assign in_ready = s_q.count != FULL;
    assign out_valid = s_q.count != '0;
    assign out_data = s_q.mem[s_q.rd];

    always_comb begin
        s_d = s_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == LAST) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == LAST) ? '0 : s_q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: s_d.count = s_q.count + 1'b1;
            2'b01: s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// file: src/dlink_buffer_ctrl.sv
// data-link message buffer and byte-count control, axi4-lite slave
// assumes a byte-wide link whose deframer strips flags and marks
// the last byte of each message; no bit stuffing is done here
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none

module dlink_buffer_ctrl (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [dlink_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dlink_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tx_link_valid,
    output dlink_pkg::link_byte_type tx_link,
    input wire logic tx_link_ready,
    input wire logic rx_link_valid,
    input wire dlink_pkg::link_byte_type rx_link,
    output logic tx_end_of_transfer,
    output logic rx_end_of_transfer
);
    import dlink_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic [11:0] aw_idx;
        logic w_have;
        logic [7:0] wbyte;
        logic wlane;
        logic signalling_mode_select;
        logic tx_frame_check_enable;
        logic idle_enable;
        logic tx_buffer_select;
        logic [6:0] tx_message_count;
        logic [1:0] busy;
        logic [1:0][95:0][7:0] txbuf;
        logic [1:0][95:0][7:0] rxbuf;
        logic rx_buffer_pointer;
        logic [6:0] rx_message_count;
        logic rx_wr_buf;
        logic [6:0] rx_len;
        logic [6:0] rx_reps;
        tx_state_type tx_st;
        logic tx_mos;
        logic tx_buf;
        logic [6:0] tx_idx;
        logic [6:0] tx_reps;
        logic [15:0] crc;
        logic link_valid;
        link_byte_type link;
        logic tx_eot;
        logic rx_eot;
    } ctrl_state_type;

    ctrl_state_type s_q, s_d;
    logic push_valid, push_ready, pop_valid, pop_ready;
    link_byte_type push_byte, pop_byte;

    function automatic region_type decode(input logic [11:0] idx);
        if (idx == IDX_CTRL) return REG_CTRL;
        if (idx == IDX_TXCNT) return REG_TXCNT;
        if (idx == IDX_RXCNT) return REG_RXCNT;
        if (idx >= IDX_TXBUF0 && idx < IDX_TXBUF0 + 12'(BUF_BYTES))
            return REG_TXB0;
        if (idx >= IDX_TXBUF1 && idx < IDX_TXBUF1 + 12'(BUF_BYTES))
            return REG_TXB1;
        if (idx >= IDX_RXBUF0 && idx < IDX_RXBUF0 + 12'(BUF_BYTES))
            return REG_RXB0;
        if (idx >= IDX_RXBUF1 && idx < IDX_RXBUF1 + 12'(BUF_BYTES))
            return REG_RXB1;
        return REG_NONE;
    endfunction

    // hdlc frame check, lsb first, one octet at a time
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    // byte fetch guarded so counts above the buffer depth send zeros
    function automatic logic [7:0] tx_byte(input ctrl_state_type st);
        if (st.tx_idx < BUF_BYTES) return st.txbuf[st.tx_buf][st.tx_idx];
        return 8'h00;
    endfunction

    link_fifo #(
        .WIDTH($bits(link_byte_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(push_valid),
        .in_data(push_byte),
        .in_ready(push_ready),
        .out_valid(pop_valid),
        .out_data(pop_byte),
        .out_ready(pop_ready)
    );

    // output stage keeps the link outputs registered
    assign pop_ready = !s_q.link_valid || tx_link_ready;

    always_comb begin
        region_type rg;
        logic [6:0] off;
        logic finish;
        rg = REG_NONE;
        off = '0;
        finish = 1'b0;
        s_d = s_q;
        s_d.tx_eot = 1'b0;
        s_d.rx_eot = 1'b0;
        push_valid = 1'b0;
        push_byte = '{data: FLAG_OCTET, last: 1'b0};

        if (pop_ready) begin
            s_d.link_valid = pop_valid;
            s_d.link = pop_byte;
        end

        // transmit engine
        case (s_q.tx_st)
            TX_IDLE: begin
                if (s_q.signalling_mode_select && s_q.idle_enable) begin
                    push_valid = 1'b1;
                end else if (s_q.busy[s_q.tx_buffer_select]) begin
                    s_d.tx_buf = s_q.tx_buffer_select;
                    s_d.tx_mos = s_q.signalling_mode_select;
                    s_d.tx_idx = '0;
                    s_d.tx_reps = '0;
                    s_d.crc = CRC_INIT;
                    s_d.tx_st = s_q.signalling_mode_select ? TX_OPEN
                                                           : TX_BODY;
                end else if (s_q.signalling_mode_select) begin
                    push_valid = 1'b1;
                end
            end
            TX_OPEN: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    if (s_q.tx_message_count != '0) begin
                        s_d.tx_st = TX_BODY;
                    end else if (s_q.tx_frame_check_enable) begin
                        s_d.tx_st = TX_FCS_LO;
                    end else begin
                        s_d.tx_st = TX_CLOSE;
                    end
                end
            end
            TX_BODY: begin
                push_valid = 1'b1;
                push_byte.data = tx_byte(s_q);
                if (push_ready && s_q.tx_mos) begin
                    s_d.crc = crc_step(s_q.crc, push_byte.data);
                    s_d.tx_idx = s_q.tx_idx + 7'h01;
                    // count excludes the frame check octets
                    if (s_d.tx_idx == s_q.tx_message_count) begin
                        s_d.tx_st = s_q.tx_frame_check_enable ? TX_FCS_LO
                                                              : TX_CLOSE;
                    end
                end else if (push_ready) begin
                    if (s_q.tx_idx == BOS_MSG_BYTES - 7'h01) begin
                        push_byte.last = 1'b1;
                        s_d.tx_idx = '0;
                        s_d.tx_reps = s_q.tx_reps + 7'h01;
                        // zero count never matches: repeats forever
                        if (s_q.tx_message_count != '0 &&
                            s_d.tx_reps == s_q.tx_message_count) begin
                            finish = 1'b1;
                        end
                    end else begin
                        s_d.tx_idx = s_q.tx_idx + 7'h01;
                    end
                end
            end
            TX_FCS_LO: begin
                push_valid = 1'b1;
                push_byte.data = ~s_q.crc[7:0];
                if (push_ready) begin
                    s_d.tx_st = TX_FCS_HI;
                end
            end
            TX_FCS_HI: begin
                push_valid = 1'b1;
                push_byte.data = ~s_q.crc[15:8];
                if (push_ready) begin
                    s_d.tx_st = TX_CLOSE;
                end
            end
            TX_CLOSE: begin
                push_valid = 1'b1;
                push_byte.last = 1'b1;
                finish = push_ready;
            end
            default: begin
                s_d.tx_st = TX_IDLE;
            end
        endcase
        if (finish) begin
            s_d.busy[s_q.tx_buf] = 1'b0;
            s_d.tx_eot = 1'b1;
            s_d.tx_st = TX_IDLE;
        end

        // receive side
        if (rx_link_valid) begin
            if (s_q.rx_len < BUF_BYTES) begin
                s_d.rxbuf[s_q.rx_wr_buf][s_q.rx_len] = rx_link.data;
            end
            s_d.rx_len = s_q.rx_len + 7'h01;
            if (rx_link.last) begin
                s_d.rx_len = '0;
                s_d.rx_wr_buf = !s_q.rx_wr_buf;
                s_d.rx_buffer_pointer = s_q.rx_wr_buf;
                if (s_q.signalling_mode_select) begin
                    // length counts every byte, frame check octets too
                    s_d.rx_message_count = s_q.rx_len + 7'h01;
                    s_d.rx_eot = 1'b1;
                end else if (s_q.rx_message_count != '0) begin
                    s_d.rx_reps = s_q.rx_reps + 7'h01;
                    if (s_d.rx_reps == s_q.rx_message_count) begin
                        s_d.rx_reps = '0;
                        s_d.rx_eot = 1'b1;
                    end
                end
            end
        end

        // axi write: address and data taken in either order
        if (s_axi_bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wbyte = s_axi_wdata[7:0];
            s_d.wlane = s_axi_wstrb[0];
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            rg = decode(s_q.aw_idx);
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (rg)
                REG_CTRL: begin
                    if (s_q.wlane) begin
                        s_d.signalling_mode_select =
                            s_q.wbyte[CTRL_MODE_BIT];
                        s_d.tx_frame_check_enable = s_q.wbyte[CTRL_FCS_BIT];
                        s_d.idle_enable = s_q.wbyte[CTRL_IDLE_BIT];
                    end
                end
                REG_TXCNT: begin
                    // busy set after release, so a same-cycle write wins
                    if (s_q.wlane) begin
                        s_d.tx_buffer_select = s_q.wbyte[SEL_BIT];
                        s_d.tx_message_count = s_q.wbyte[6:0];
                        s_d.busy[s_q.wbyte[SEL_BIT]] = 1'b1;
                    end
                end
                REG_RXCNT: begin
                    // a message ending in the same cycle keeps its result
                    if (s_q.wlane && !(rx_link_valid && rx_link.last)) begin
                        s_d.rx_buffer_pointer = s_q.wbyte[SEL_BIT];
                        s_d.rx_message_count = s_q.wbyte[6:0];
                        s_d.rx_reps = '0;
                    end
                end
                REG_TXB0, REG_TXB1: begin
                    off = (rg == REG_TXB0) ? 7'(s_q.aw_idx - IDX_TXBUF0)
                                           : 7'(s_q.aw_idx - IDX_TXBUF1);
                    if (s_q.wlane) begin
                        s_d.txbuf[rg == REG_TXB1][off] = s_q.wbyte;
                    end
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_have;
        s_d.wready = !s_d.w_have;

        // axi read: one cycle from address to data
        if (s_axi_rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            rg = decode(s_axi_araddr[ADDR_W-1:2]);
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            case (rg)
                REG_CTRL: begin
                    s_d.rdata[CTRL_MODE_BIT] = s_q.signalling_mode_select;
                    s_d.rdata[CTRL_FCS_BIT] = s_q.tx_frame_check_enable;
                    s_d.rdata[CTRL_IDLE_BIT] = s_q.idle_enable;
                end
                REG_TXCNT: begin
                    // reads buffer 0's busy flag, not the written value
                    s_d.rdata[SEL_BIT] = s_q.busy[0];
                    s_d.rdata[6:0] = s_q.tx_message_count;
                end
                REG_RXCNT: begin
                    s_d.rdata[SEL_BIT] = s_q.rx_buffer_pointer;
                    s_d.rdata[6:0] = s_q.rx_message_count;
                end
                REG_TXB0: begin
                    off = 7'(s_axi_araddr[ADDR_W-1:2] - IDX_TXBUF0);
                    s_d.rdata[7:0] = s_q.txbuf[0][off];
                end
                REG_TXB1: begin
                    off = 7'(s_axi_araddr[ADDR_W-1:2] - IDX_TXBUF1);
                    s_d.rdata[7:0] = s_q.txbuf[1][off];
                end
                REG_RXB0: begin
                    off = 7'(s_axi_araddr[ADDR_W-1:2] - IDX_RXBUF0);
                    s_d.rdata[7:0] = s_q.rxbuf[0][off];
                end
                REG_RXB1: begin
                    off = 7'(s_axi_araddr[ADDR_W-1:2] - IDX_RXBUF1);
                    s_d.rdata[7:0] = s_q.rxbuf[1][off];
                end
                default: begin
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = s_q.rdata;
    assign tx_link_valid = s_q.link_valid;
    assign tx_link = s_q.link;
    assign tx_end_of_transfer = s_q.tx_eot;
    assign rx_end_of_transfer = s_q.rx_eot;

endmodule

`default_nettype wire

// file: dv/dlink_buffer_ctrl_props.sv
// port checker for the data-link buffer controller
// assumes one clock domain and the top module's own port names
`default_nettype none

module dlink_buffer_ctrl_props (
    input wire logic mclk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_link_valid,
    input wire dlink_pkg::link_byte_type tx_link,
    input wire logic tx_link_ready,
    input wire logic rx_link_valid,
    input wire dlink_pkg::link_byte_type rx_link,
    input wire logic tx_end_of_transfer,
    input wire logic rx_end_of_transfer
);
    import dlink_pkg::*;
    logic last_seen;
    assign last_seen = rx_link_valid && rx_link.last;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    tx_hold_a: assert property (tx_link_valid && !tx_link_ready |=>
        tx_link_valid && $stable(tx_link)) else $error("link byte dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    tx_pulse_a: assert property (
        tx_end_of_transfer |=> !tx_end_of_transfer) else $error("tx pulse");
    rx_cause_a: assert property (
        rx_end_of_transfer |-> $past(last_seen)) else $error("rx cause");
    rx_pulse_a: assert property (
        rx_end_of_transfer |=> !rx_end_of_transfer || $past(last_seen))
        else $error("rx pulse");
endmodule

bind dlink_buffer_ctrl dlink_buffer_ctrl_props chk (.*);

`default_nettype wire

// file: dv/link_partner.sv
// remote terminal: sinks transmit bytes with random stalls and
// plays queued receive bytes; assumes the block's clock and reset
`default_nettype none

module link_partner (
    input wire logic mclk,
    input wire logic srst,
    input wire logic tx_link_valid,
    input wire dlink_pkg::link_byte_type tx_link,
    output logic tx_link_ready,
    output logic rx_link_valid,
    output dlink_pkg::link_byte_type rx_link
);
    import dlink_pkg::*;
    int seed = 32'h0ddc;
    int lasts = 0;
    link_byte_type got[$];
    link_byte_type rxq[$];
    initial begin
        tx_link_ready = 0;
        rx_link_valid = 0;
        rx_link = '0;
    end
    always @(posedge mclk) begin
        if (tx_link_valid && tx_link_ready && !srst) begin
            got.push_back(tx_link);
            lasts += tx_link.last;
        end
        tx_link_ready <= ($random(seed) % 4) != 0;
        if (rxq.size() > 0 && ($random(seed) % 3) != 0) begin
            rx_link_valid <= 1;
            rx_link <= rxq.pop_front();
        end else begin
            // an idle line shows garbage, the last bit toggling too
            rx_link_valid <= 0;
            rx_link <= ~rx_link;
        end
    end
endmodule

`default_nettype wire

// file: dv/dlink_buffer_ctrl_tb.sv
// self-checking bench for the data-link buffer controller
// assumes link_partner on the link side and the bound checker
`default_nettype none

module dlink_buffer_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dlink_pkg::*;
    logic mclk = 0, srst = 1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_link_valid, tx_link_ready, rx_link_valid;
    logic tx_end_of_transfer, rx_end_of_transfer;
    link_byte_type tx_link, rx_link;
    int mismatches = 0, num_checks = 0, seed = 32'h0ddc;
    int tx_eots = 0, rx_eots = 0, n;
    logic [7:0] b[6];
    logic [15:0] crc;

    dlink_buffer_ctrl uut (.*);
    link_partner pt (.*);
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        tx_eots += tx_end_of_transfer;
        rx_eots += rx_end_of_transfer;
    end

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        // a late bready now and then makes the slave hold its answer
        s_axi_bready <= 1'($random(seed));
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
    endtask

    task automatic rdr(input logic [11:0] i);
        @(posedge mclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1'($random(seed));
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // generous: the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        mismatches++;
        complete_run;
    end

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 0;
        rdr(IDX_TXCNT);
        chk(rd, 0);
        rdr(IDX_RXCNT);
        chk(rd, 0);
        rdr(12'h100);
        chk({rsp, rd}, {RESP_SLVERR, 32'h0});
        wr(IDX_RXBUF0, 8'h11);
        chk(rsp, RESP_SLVERR);
        $display("test registers done");
        for (int k = 0; k < 6; k++) b[k] = 8'($random(seed));
        wr(IDX_TXBUF0, b[0]);
        wr(IDX_TXBUF0 + 12'h1, b[1]);
        wr(IDX_TXCNT, 8'h03);
        rdr(IDX_TXCNT);
        chk(rd[7], 1);
        wait (pt.lasts == 3);
        repeat (20) @(posedge mclk);
        chk(tx_eots, 1);
        chk(pt.got.size(), 6);
        for (int k = 0; k < 6; k++) chk(pt.got[k], {b[k%2], k%2 == 1});
        rdr(IDX_TXCNT);
        chk(rd[7], 0);
        $display("test bit-oriented transmit done");
        wr(IDX_CTRL, 8'h03);
        for (int k = 0; k < 3; k++) wr(IDX_TXBUF1 + 12'(k), b[k+2]);
        crc = CRC_INIT;
        for (int k = 2; k < 5; k++)
            for (int j = 0; j < 8; j++)
                crc = (crc >> 1) ^ ((crc[0] ^ b[k][j]) ? CRC_POLY : 16'h0);
        crc = ~crc;
        pt.got.delete();
        wr(IDX_TXCNT, 8'h83);
        rdr(IDX_TXCNT);
        chk(rd[7], 0);
        wait (pt.lasts == 4);
        n = pt.got.size();
        chk(pt.got[n-1], {FLAG_OCTET, 1'b1});
        chk(pt.got[n-2], {crc[15:8], 1'b0});
        chk(pt.got[n-3], {crc[7:0], 1'b0});
        for (int k = 0; k < 3; k++) chk(pt.got[n-6+k], {b[k+2], 1'b0});
        chk(pt.got[n-7], {FLAG_OCTET, 1'b0});
        $display("test message transmit done");
        wr(IDX_CTRL, 8'h05);
        wr(IDX_TXCNT, 8'h01);
        repeat (40) @(posedge mclk);
        pt.got.delete();
        repeat (40) @(posedge mclk);
        chk(pt.got.size() > 0, 1);
        chk(pt.lasts, 4);
        foreach (pt.got[k]) chk(pt.got[k], {FLAG_OCTET, 1'b0});
        $display("test idle flags done");
        wr(IDX_CTRL, 8'h01);
        for (int k = 0; k < 5; k++) pt.rxq.push_back({b[k], k == 4});
        wait (rx_eots == 1);
        rdr(IDX_RXCNT);
        chk(rd, 32'h05);
        rdr(IDX_RXBUF0 + 12'h2);
        chk(rd, {24'h0, b[2]});
        for (int k = 0; k < 3; k++) pt.rxq.push_back({b[k+3], k == 2});
        wait (rx_eots == 2);
        rdr(IDX_RXCNT);
        chk(rd, 32'h83);
        rdr(IDX_RXBUF1);
        chk(rd, {24'h0, b[3]});
        $display("test message receive done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_RXCNT, 8'h02);
        repeat (2) begin
            pt.rxq.push_back({b[0], 1'b0});
            pt.rxq.push_back({b[1], 1'b1});
        end
        wait (rx_eots == 3);
        chk(pt.rxq.size(), 0);
        wr(IDX_RXCNT, 8'h00);
        repeat (3) begin
            pt.rxq.push_back({b[0], 1'b0});
            pt.rxq.push_back({b[1], 1'b1});
        end
        wait (pt.rxq.size() == 0);
        repeat (4) @(posedge mclk);
        chk(rx_eots, 3);
        $display("test bit-oriented receive done");
        complete_run;
    end
endmodule

`default_nettype wire
